// file: design/vssc_top.sv
// sync source selection, polarity, clamp, pll hold and power control with register bank
// Function
// - hsync polarity: auto unless override set
// - input polarity bit: 0 low, 1 high
// - hsync output high pulse at 0
// - hsync source override else auto detect
// - select: pin or green; override/both-active
// - vsync output inverted when bit is 0
// - vsync select raw/separated: override else auto detect
// - clamp from hsync or external pin
// - external clamp polarity selectable
// - pll hold from pin or vsync
// - hold polarity auto unless override set
// - hold polarity bit: 0 low, 1 high
// - seek bit permits low power mode
// - active low full power down
// - red/blue clamp ground or midscale
// - separator counts 5 MHz ticks to threshold
// - hold asserted lead lines before vsync
// - hold kept trail lines after vsync
// - status reports hsync and green presence
// - registers reached over serial port
`timescale 1ns/1ps
`default_nettype none
module vssc_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    // byte-wide register port, decoded from the serial port front end
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire vssc_pkg::vssc_sync_in_t sync_i,
    output vssc_pkg::vssc_ctrl_out_t ctrl_o
);
    logic [7:0] sync_ctrl_q;
    logic [7:0] clamp_ctrl_q;
    logic [7:0] green_ctrl_q;
    logic [7:0] sep_thr_q;
    logic [7:0] lead_q;
    logic [7:0] trail_q;

    // register writes; sparse map, unmapped writes are dropped
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_ctrl_q <= vssc_pkg::RST_SYNC_CTRL;
            clamp_ctrl_q <= vssc_pkg::RST_CLAMP_CTRL;
            green_ctrl_q <= vssc_pkg::RST_GREEN_CTRL;
            sep_thr_q <= vssc_pkg::RST_SEP_THR;
            lead_q <= vssc_pkg::RST_LEAD;
            trail_q <= vssc_pkg::RST_TRAIL;
        end
        else if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                vssc_pkg::ADDR_SYNC_CTRL: sync_ctrl_q <= reg_wdata_i;
                vssc_pkg::ADDR_CLAMP_CTRL:
                    clamp_ctrl_q <= reg_wdata_i & vssc_pkg::CLAMP_CTRL_WMASK;
                // bit 0 is stored as written; the controller must set it
                vssc_pkg::ADDR_GREEN_CTRL: green_ctrl_q <= reg_wdata_i;
                vssc_pkg::ADDR_SEP_THR: sep_thr_q <= reg_wdata_i;
                vssc_pkg::ADDR_LEAD: lead_q <= reg_wdata_i;
                vssc_pkg::ADDR_TRAIL: trail_q <= reg_wdata_i;
                default:
                begin
                end
            endcase
        end
    end

    // polarity detection: sample level a while after an edge is absent; simple
    // majority proxy is the idle level, so the sync's active level is its inverse
    logic hs_idle_q;
    logic hold_idle_q;
    logic hs_prev_q;
    logic [7:0] hs_stable_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hs_prev_q <= 1'b0;
            hs_stable_q <= 8'h00;
            hs_idle_q <= 1'b0;
            hold_idle_q <= 1'b0;
        end
        else
        begin
            hs_prev_q <= sync_i.hsync_pin;
            if (sync_i.hsync_pin != hs_prev_q)
                hs_stable_q <= 8'h00;
            else if (hs_stable_q != 8'hff)
                hs_stable_q <= hs_stable_q + 8'h01;
            // a level held long is the idle level, not the pulse
            if (hs_stable_q == 8'hfe)
                hs_idle_q <= hs_prev_q;
            hold_idle_q <= sync_i.vsync_pin ? hold_idle_q : sync_i.hold_pin;
        end
    end

    logic hpol_high;
    logic hold_pol_high;
    assign hpol_high = sync_ctrl_q[vssc_pkg::B_HPOL_OVR] ?
                       sync_ctrl_q[vssc_pkg::B_HPOL_IN] : ~hs_idle_q;
    assign hold_pol_high = clamp_ctrl_q[vssc_pkg::B_HOLD_POL_OVR] ?
                           clamp_ctrl_q[vssc_pkg::B_HOLD_POL] : ~hold_idle_q;

    // automatic source choice; green wins when only green is present, or when both are present and the select bit is set
    logic auto_ahs;
    logic active_hsync_indication;
    logic both_hs;
    assign both_hs = sync_i.hs_present & sync_i.sog_present;
    assign auto_ahs = both_hs ? sync_ctrl_q[vssc_pkg::B_AHS_SEL] :
                      (~sync_i.hs_present & sync_i.sog_present);
    assign active_hsync_indication = sync_ctrl_q[vssc_pkg::B_AHS_OVR] ?
                 sync_ctrl_q[vssc_pkg::B_AHS_SEL] : auto_ahs;

    logic hs_raw;
    logic hs_active;
    assign hs_raw = active_hsync_indication ? sync_i.sog_sync : sync_i.hsync_pin;
    // the green slicer output is taken as active high already
    assign hs_active = active_hsync_indication ? hs_raw : (hs_raw ~^ hpol_high);

    // sync separator: count 5 MHz ticks of active composite sync
    logic [4:0] div_q;
    logic tick;
    logic [7:0] sep_cnt_q;
    logic sep_vs_q;
    assign tick = (div_q == vssc_pkg::SEP_DIV_LAST);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            div_q <= 5'h00;
        else if (tick)
            div_q <= 5'h00;
        else
            div_q <= div_q + 5'h01;
    end

    // pulses longer than the threshold are vertical sync; shorter are hsync
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sep_cnt_q <= 8'h00;
            sep_vs_q <= 1'b0;
        end
        else if (tick)
        begin
            if (hs_active != sep_vs_q)
            begin
                if (sep_cnt_q >= sep_thr_q)
                begin
                    sep_vs_q <= hs_active;
                    sep_cnt_q <= 8'h00;
                end
                else
                    sep_cnt_q <= sep_cnt_q + 8'h01;
            end
            else
                sep_cnt_q <= 8'h00;
        end
    end

    logic active_vsync_indication;
    logic vs_active;
    assign active_vsync_indication = sync_ctrl_q[vssc_pkg::B_AVS_OVR] ?
                 sync_ctrl_q[vssc_pkg::B_AVS_SEL] :
                 (~sync_i.vs_present & sync_i.sog_present);
    assign vs_active = active_vsync_indication ? sep_vs_q : sync_i.vsync_pin;

    // hold window: lead lines are realised by counting lines since the last vsync
    // and asserting when a frame of equal length is that close to ending
    logic hs_prev_act_q;
    logic vs_prev_q;
    logic hs_rise;
    logic vs_rise;
    logic vs_fall;
    logic [15:0] line_q;
    logic [15:0] frame_len_q;
    logic [7:0] trail_cnt_q;
    logic trail_on_q;
    assign hs_rise = hs_active & ~hs_prev_act_q;
    assign vs_rise = vs_active & ~vs_prev_q;
    assign vs_fall = ~vs_active & vs_prev_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hs_prev_act_q <= 1'b0;
            vs_prev_q <= 1'b0;
            line_q <= 16'h0000;
            frame_len_q <= 16'h0000;
            trail_cnt_q <= 8'h00;
            trail_on_q <= 1'b0;
        end
        else
        begin
            hs_prev_act_q <= hs_active;
            vs_prev_q <= vs_active;
            if (vs_rise)
            begin
                frame_len_q <= line_q;
                line_q <= 16'h0000;
            end
            else if (hs_rise && line_q != 16'hffff)
                line_q <= line_q + 16'h0001;
            if (vs_fall)
            begin
                trail_cnt_q <= trail_q;
                trail_on_q <= (trail_q != 8'h00);
            end
            else if (trail_on_q && hs_rise)
            begin
                trail_cnt_q <= trail_cnt_q - 8'h01;
                trail_on_q <= (trail_cnt_q != 8'h01);
            end
        end
    end

    logic lead_on;
    logic int_hold;
    logic ext_hold;
    // opens when the lines left before the predicted vsync equal the lead count
    assign lead_on = (lead_q != 8'h00) && (frame_len_q != 16'h0000) &&
                     (({1'b0, line_q} + {9'h000, lead_q}) > {1'b0, frame_len_q});
    assign int_hold = vs_active | lead_on | trail_on_q;
    assign ext_hold = sync_i.hold_pin ~^ hold_pol_high;

    logic clamp_ext;
    assign clamp_ext = sync_i.clamp_pin ^ clamp_ctrl_q[vssc_pkg::B_CLAMP_POL];

    logic [7:0] detect;
    assign detect = {sync_i.hs_present, active_hsync_indication, hpol_high, sync_i.vs_present, active_vsync_indication,
                     ~sync_ctrl_q[vssc_pkg::B_VS_OUT_INV], sync_i.sog_present,
                     hold_pol_high};

    // outputs registered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_o <= '0;
        else
        begin
            ctrl_o.hsync <= hs_active ^ sync_ctrl_q[vssc_pkg::B_HPOL_OUT];
            ctrl_o.vsync <= vs_active ^ ~sync_ctrl_q[vssc_pkg::B_VS_OUT_INV];
            ctrl_o.clamp <= clamp_ctrl_q[vssc_pkg::B_CLAMP_EXT] ? clamp_ext : hs_active;
            ctrl_o.pll_hold <= clamp_ctrl_q[vssc_pkg::B_HOLD_SRC] ? int_hold : ext_hold;
            ctrl_o.hpol_high <= hpol_high;
            ctrl_o.red_mid <= green_ctrl_q[vssc_pkg::B_RED_MID];
            ctrl_o.blue_mid <= green_ctrl_q[vssc_pkg::B_BLUE_MID];
            ctrl_o.low_power_ok <= clamp_ctrl_q[vssc_pkg::B_SEEK_OK];
            ctrl_o.power_down <= ~clamp_ctrl_q[vssc_pkg::B_FULL_POWER_DOWN_N_N];
            ctrl_o.slicer_level <= green_ctrl_q[7:3];
        end
    end

    // read port: one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
            begin
                unique case (reg_addr_i)
                    vssc_pkg::ADDR_SYNC_CTRL: reg_rdata_o <= sync_ctrl_q;
                    vssc_pkg::ADDR_CLAMP_CTRL: reg_rdata_o <= clamp_ctrl_q;
                    vssc_pkg::ADDR_GREEN_CTRL: reg_rdata_o <= green_ctrl_q;
                    vssc_pkg::ADDR_SEP_THR: reg_rdata_o <= sep_thr_q;
                    vssc_pkg::ADDR_LEAD: reg_rdata_o <= lead_q;
                    vssc_pkg::ADDR_TRAIL: reg_rdata_o <= trail_q;
                    vssc_pkg::ADDR_DETECT: reg_rdata_o <= detect;
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: design/vssc_pkg.sv
// package: register map, field positions and reset values of the sync select control bank
package vssc_pkg;
    localparam logic [7:0] ADDR_SYNC_CTRL = 8'h0e;
    localparam logic [7:0] ADDR_CLAMP_CTRL = 8'h0f;
    localparam logic [7:0] ADDR_GREEN_CTRL = 8'h10;
    localparam logic [7:0] ADDR_SEP_THR = 8'h11;
    localparam logic [7:0] ADDR_LEAD = 8'h12;
    localparam logic [7:0] ADDR_TRAIL = 8'h13;
    localparam logic [7:0] ADDR_DETECT = 8'h14;

    localparam logic [7:0] RST_SYNC_CTRL = 8'h40;
    localparam logic [7:0] RST_CLAMP_CTRL = 8'h4e;
    localparam logic [7:0] RST_GREEN_CTRL = 8'h78;
    localparam logic [7:0] RST_SEP_THR = 8'h20;
    localparam logic [7:0] RST_LEAD = 8'h00;
    localparam logic [7:0] RST_TRAIL = 8'h00;
    localparam logic [7:0] CLAMP_CTRL_WMASK = 8'hfe;

    // sync_source_control bits
    localparam int B_HPOL_OVR = 7;
    localparam int B_HPOL_IN = 6;
    localparam int B_HPOL_OUT = 5;
    localparam int B_AHS_OVR = 4;
    localparam int B_AHS_SEL = 3;
    localparam int B_VS_OUT_INV = 2;
    localparam int B_AVS_OVR = 1;
    localparam int B_AVS_SEL = 0;
    // clamp_hold_power_control bits
    localparam int B_CLAMP_EXT = 7;
    localparam int B_CLAMP_POL = 6;
    localparam int B_HOLD_SRC = 5;
    localparam int B_HOLD_POL_OVR = 4;
    localparam int B_HOLD_POL = 3;
    localparam int B_SEEK_OK = 2;
    localparam int B_FULL_POWER_DOWN_N_N = 1;
    // green_slicer_clamp_select bits
    localparam int B_RED_MID = 2;
    localparam int B_BLUE_MID = 1;
    // sync detect bits
    localparam int B_DET_HS = 7;
    localparam int B_DET_AHS = 6;
    localparam int B_DET_HPOL = 5;
    localparam int B_DET_VS = 4;
    localparam int B_DET_AVS = 3;
    localparam int B_DET_VPOL = 2;
    localparam int B_DET_SOG = 1;
    localparam int B_DET_HOLDPOL = 0;

    localparam int CLK_HZ = 100_000_000;
    localparam int SEP_REF_HZ = 5_000_000;
    localparam int SEP_DIV = CLK_HZ / SEP_REF_HZ;
    localparam logic [4:0] SEP_DIV_LAST = 5'(SEP_DIV - 1);

    typedef struct packed {
        logic hsync_pin;
        logic sog_sync;
        logic vsync_pin;
        logic clamp_pin;
        logic hold_pin;
        logic hs_present;
        logic vs_present;
        logic sog_present;
    } vssc_sync_in_t;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic clamp;
        logic pll_hold;
        logic hpol_high;
        logic red_mid;
        logic blue_mid;
        logic low_power_ok;
        logic power_down;
        logic [4:0] slicer_level;
    } vssc_ctrl_out_t;
endpackage

// file: test/vssc_assertions.sv
// checker: register port and sync control relations of the sync select bank
`timescale 1ns/1ps
`default_nettype none
module vssc_assertions
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire vssc_pkg::vssc_sync_in_t sync_i,
    input wire vssc_pkg::vssc_ctrl_out_t ctrl_o
);
    logic rst_q;
    logic rst_qq;
    logic [7:0] sc_q;
    logic [7:0] ch_q;
    logic [7:0] gc_q;
    default clocking cb @(posedge clk_i);
    endclocking
    // outputs lag the registers by a flop, so the edge after release is skipped;
    // two shadow flops because the disable term is read unsampled
    default disable iff (rst_i || rst_q || rst_qq);
    always_ff @(posedge clk_i)
    begin
        rst_q <= rst_i;
        rst_qq <= rst_q;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sc_q <= vssc_pkg::RST_SYNC_CTRL;
            ch_q <= vssc_pkg::RST_CLAMP_CTRL;
            gc_q <= vssc_pkg::RST_GREEN_CTRL;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                vssc_pkg::ADDR_SYNC_CTRL: sc_q <= reg_wdata_i;
                vssc_pkg::ADDR_CLAMP_CTRL: ch_q <= reg_wdata_i & vssc_pkg::CLAMP_CTRL_WMASK;
                vssc_pkg::ADDR_GREEN_CTRL: gc_q <= reg_wdata_i;
                default: ;
            endcase
        end
    end
    sequence clamp_rd_s;
        reg_rd_i && reg_addr_i == vssc_pkg::ADDR_CLAMP_CTRL;
    endsequence
    sequence pin_hold_s;
        !ch_q[5] && ch_q[4];
    endsequence
    AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read answer missing");
    AST_CLAMP_RD: assert property (clamp_rd_s |=> reg_rdata_o == {$past(ch_q[7:1]), 1'b0})
        else $error("clamp register read wrong");
    AST_FULL_POWER_DOWN_N: assert property (ctrl_o.power_down != $past(ch_q[1]))
        else $error("power down wrong");
    AST_SEEK: assert property (ctrl_o.low_power_ok == $past(ch_q[2]))
        else $error("low power permission wrong");
    AST_MID: assert property ({ctrl_o.red_mid, ctrl_o.blue_mid} == $past(gc_q[2:1]))
        else $error("clamp reference wrong");
    AST_EXT_CLAMP: assert property (ch_q[7] |=> ctrl_o.clamp == $past(sync_i.clamp_pin ^ ch_q[6]))
        else $error("external clamp wrong");
    AST_HOLD_PIN: assert property (pin_hold_s |=> ctrl_o.pll_hold == $past(sync_i.hold_pin ~^ ch_q[3]))
        else $error("hold from pin wrong");
    AST_HSYNC_PIN: assert property (sc_q[7] && sc_q[4] && !sc_q[3] |=>
        ctrl_o.hsync == $past(sync_i.hsync_pin ^ ~sc_q[6] ^ sc_q[5]))
        else $error("hsync output wrong");
    AST_HPOL: assert property (sc_q[7] |=> ctrl_o.hpol_high == $past(sc_q[6]))
        else $error("hsync polarity wrong");
    AST_VSYNC_RAW: assert property (sc_q[1] && !sc_q[0] |=>
        ctrl_o.vsync == $past(sync_i.vsync_pin ^ ~sc_q[2]))
        else $error("vsync output wrong");
endmodule
bind vssc_top vssc_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .sync_i(sync_i), .ctrl_o(ctrl_o));
`default_nettype wire

// file: test/vssc_video_source.sv
// partner: video source making periodic hsync and vsync lines
`timescale 1ns/1ps
`default_nettype none
module vssc_video_source
#(
    parameter int LINE_CLKS = 64,
    parameter int PULSE_CLKS = 8,
    parameter int FRAME_LINES = 16,
    parameter int VS_LINES = 3
)
(
    input wire logic clk_i,
    input wire logic run_i,
    output logic hsync_o,
    output logic vsync_o
);
    int pix = 0;
    int line = 0;
    initial
    begin
        hsync_o = 1'b0;
        vsync_o = 1'b0;
    end
    // lines freeze outside a run, like a source that is switched off
    always @(posedge clk_i)
    begin
        if (run_i)
        begin
            pix <= (pix == LINE_CLKS - 1) ? 0 : pix + 1;
            if (pix == LINE_CLKS - 1)
                line <= (line == FRAME_LINES - 1) ? 0 : line + 1;
            hsync_o <= pix < PULSE_CLKS;
            vsync_o <= line < VS_LINES;
        end
    end
endmodule
`default_nettype wire

// file: test/video_sync_select_control_bench.sv
// bench: register bank and sync selection checks of the sync select control block
`timescale 1ns/1ps
`default_nettype none
module video_sync_select_control_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] rdat;
    logic rval;
    logic run = 1'b0;
    logic src_h;
    logic src_v;
    vssc_pkg::vssc_sync_in_t sin = '0;
    vssc_pkg::vssc_sync_in_t sync_w;
    vssc_pkg::vssc_ctrl_out_t co;
    logic [7:0] shd [6];
    logic [7:0] got;
    logic [8:0] r;
    int seed = 32'h9998;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    always_comb
    begin
        sync_w = sin;
        if (run)
        begin
            sync_w.hsync_pin = src_h;
            sync_w.vsync_pin = src_v;
        end
    end
    vssc_top i_dut (.clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdat), .reg_rdata_o(rdat), .reg_rvalid_o(rval), .sync_i(sync_w), .ctrl_o(co));
    vssc_video_source i_src (.clk_i(clk), .run_i(run), .hsync_o(src_h), .vsync_o(src_v));
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a >= 8'h0e && a <= 8'h13)
            shd[a - 8'h0e] = (a == vssc_pkg::ADDR_CLAMP_CTRL) ? d & 8'hfe : d;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({7'h00, rval}, 8'h01);
        got = rdat;
    endtask
    task automatic chk_all;
        for (int i = 0; i < 6; i++)
        begin
            rreg(8'h0e + 8'(i));
            chk(got, shd[i]);
        end
    endtask
    task automatic at(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] exp_out(input vssc_pkg::vssc_sync_in_t s, input logic [8:0] c);
        logic ah;
        ah = s.hsync_pin ^ ~c[1];
        return {3'h0, c[1], ah ^ c[0], s.vsync_pin ^ ~c[2], c[3] ? s.clamp_pin ^ c[4] : ah,
            s.hold_pin ~^ c[5]};
    endfunction
    // p: {select bit, green present, hsync present}; green is used alone or when selected
    function automatic logic exp_ahs(input logic [2:0] p);
        return p[1] && (!p[0] || p[2]);
    endfunction
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            report_and_stop;
        end
    end
    initial
    begin
        shd = '{vssc_pkg::RST_SYNC_CTRL, vssc_pkg::RST_CLAMP_CTRL, vssc_pkg::RST_GREEN_CTRL,
            8'h20, 8'h00, 8'h00};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk_all;
        $display("test reset values done");
        for (int i = 0; i < 30; i++)
        begin
            r = 9'($random(seed));
            wreg(8'h0e + 8'(r[8:6] % 6), 8'($random(seed)));
            rreg(8'h0e + 8'(r[8:6] % 6));
            chk(got, shd[r[8:6] % 6]);
        end
        wreg(vssc_pkg::ADDR_DETECT, 8'hff);
        wreg(8'h30, 8'hff);
        chk_all;
        rreg(8'h30);
        chk(got, 8'h00);
        $display("test register access done");
        for (int k = 0; k < 4; k++)
        begin
            wreg(vssc_pkg::ADDR_GREEN_CTRL, {5'h0f, 2'(k), 1'b1});
            wreg(vssc_pkg::ADDR_CLAMP_CTRL, {5'h09, 2'(k), 1'b0});
            at(2);
            chk({4'h0, co.red_mid, co.blue_mid, co.low_power_ok, !co.power_down}, {4'h0, 2'(k), 2'(k)});
            chk({3'h0, co.slicer_level}, 8'h0f);
        end
        for (int i = 0; i < 40; i++)
        begin
            r = 9'($random(seed));
            wreg(vssc_pkg::ADDR_SYNC_CTRL, {1'b1, r[1:0], 2'b10, r[2], 2'b10});
            wreg(vssc_pkg::ADDR_CLAMP_CTRL, {r[3], r[4], 2'b01, r[5], 3'b110});
            sin <= vssc_pkg::vssc_sync_in_t'($random(seed));
            at(2);
            chk({3'h0, co.hpol_high, co.hsync, co.vsync, co.clamp, co.pll_hold}, exp_out(sin, r));
        end
        for (int k = 1; k < 8; k++)
        begin
            wreg(vssc_pkg::ADDR_SYNC_CTRL, {4'hc, k[2], 3'b110});
            sin <= {1'b1, 4'h0, k[0], 1'b1, k[1]};
            at(2);
            chk({7'h00, co.hsync}, {7'h00, !exp_ahs(3'(k))});
            rreg(vssc_pkg::ADDR_DETECT);
            chk(got & 8'hc2, {k[0], exp_ahs(3'(k)), 4'h0, k[1], 1'b0});
        end
        $display("test sync selection done");
        wreg(vssc_pkg::ADDR_SYNC_CTRL, 8'h16);
        wreg(vssc_pkg::ADDR_CLAMP_CTRL, 8'h06);
        sin <= 8'h8e;
        at(300);
        chk({5'h0, co.hpol_high, co.hsync, co.pll_hold}, 8'h00);
        wreg(vssc_pkg::ADDR_SEP_THR, 8'h04);
        wreg(vssc_pkg::ADDR_SYNC_CTRL, 8'hdf);
        sin <= 8'h06;
        at(200);
        @(posedge clk);
        sin <= 8'hc6;
        at(40);
        chk({7'h00, co.vsync}, 8'h00);
        at(160);
        chk({7'h00, co.vsync}, 8'h01);
        $display("test polarity and separator done");
        wreg(vssc_pkg::ADDR_LEAD, 8'h02);
        wreg(vssc_pkg::ADDR_TRAIL, 8'h02);
        wreg(vssc_pkg::ADDR_SYNC_CTRL, 8'hd6);
        wreg(vssc_pkg::ADDR_CLAMP_CTRL, 8'h26);
        sin <= 8'h06;
        run <= 1'b1;
        @(negedge src_v);
        @(negedge src_v);
        at(32);
        chk({7'h00, co.pll_hold}, 8'h01);
        at(224);
        chk({7'h00, co.pll_hold}, 8'h00);
        at(416);
        chk({7'h00, co.pll_hold}, 8'h00);
        at(96);
        chk({7'h00, co.pll_hold}, 8'h01);
        $display("test pll hold window done");
        report_and_stop;
    end
endmodule
`default_nettype wire
